//--- vtl_core.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [R1] format descriptor bit 7 reads absolute 0, bits 6:5 read linear 00
// [R2] format parameter reads 10110b, exponent -10, lsb 0.9765625 mV
// [R3] target is paged 16-bit unsigned, word write and word readback
// [R4] target writes are refused while avs bus owns the output
// [R5] target or offset changes ramp at the slew setting rate
// [R6] dac reference is clamped to ceiling above and floor below
// [R7] clamping sets no status bit and raises no alert
// [R8] sum limit: 1.870 V, 3.740 V by ceiling, 5.500 V at half scale
// [R9] out-of-range target, offset or ceiling writes, and format writes, flag invalid data
// [R10] ceiling may not cross 1.87 V while converting
// [R11] channel a boot target from nvm if select 0, strap if 1
// [R12] channel b boot target always from nvm
// [R13] boot target kept apart; restore control reloads it on enable
// [R14] offset is 16-bit two's complement added to the target
// [R15] nvm offset image is sign plus seven bits picked by range extend
// [R16] range extend trades offset resolution for range
// [R17] while converting, lowered ceiling applies at next new target or phase event; when not converting, at once
// [R18] nvm boot restores ceiling from nvm
// [R19] strap boot sets ceiling 1.870 V or 3.740 V by strap value
// [R20] any ceiling up to 5.500 V accepted while not converting
// [R21] target and offset read back as written, even when clamped
module vtl_core (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic cmd_valid_in,
   input wire logic cmd_write_in,
   input wire logic cmd_page_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic [15:0] cmd_wdata_in,
   input wire logic avs_control_in,
   input wire logic [1:0] conversion_active_in,
   input wire logic [1:0] channel_enable_in,
   input wire logic [1:0] phase_event_in,
   input wire logic [1:0] feedback_loop_scale_in,
   input wire logic [15:0] output_voltage_floor_in,
   input wire logic [15:0] output_slew_setting_in,
   input wire logic boot_source_select_in,
   input wire logic boot_restore_control_in,
   input wire logic [1:0] offset_range_extend_in,
   input wire logic [15:0] channel_a_boot_strap_pin_in,
   input wire logic [15:0] nvm_target_a_in,
   input wire logic [15:0] nvm_target_b_in,
   input wire logic [15:0] nvm_ceiling_a_in,
   input wire logic [15:0] nvm_ceiling_b_in,
   input wire logic [7:0] nvm_offset_a_in,
   input wire logic [7:0] nvm_offset_b_in,
   input wire logic status_clear_in,
   output logic cmd_ack_out,
   output logic [15:0] cmd_rdata_out,
   output logic invalid_data_out,
   output logic [15:0] dac_ref_a_out,
   output logic [15:0] dac_ref_b_out,
   output logic [7:0] nvm_offset_image_a_out,
   output logic [7:0] nvm_offset_image_b_out
);
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [15:0] limit_of(input logic [15:0] c,
                                            input logic half);
      if (half) return vtl_pkg::LIM_HIGH; // R8
      if (c <= vtl_pkg::LIM_LOW) return vtl_pkg::LIM_LOW; // R8
      return vtl_pkg::LIM_MID; // R8
   endfunction : limit_of

   function automatic logic signed [17:0] sum_of(input logic [15:0] t,
                                                 input logic [15:0] o);
      return $signed({2'h0, t}) + $signed({{2{o[15]}}, o}); // R14
   endfunction : sum_of

   function automatic logic sum_ok(input logic signed [17:0] s,
                                   input logic [15:0] c,
                                   input logic half);
      return !s[17] && (s[15:0] <= limit_of(c, half)) && !s[16];
   endfunction : sum_ok

   function automatic logic [15:0] clamp(input logic signed [17:0] s,
                                         input logic [15:0] c,
                                         input logic [15:0] f);
      if (!s[17] && (s > $signed({2'h0, c}))) return c; // R6
      if (s < $signed({2'h0, f})) return f; // R6
      return s[15:0];
   endfunction : clamp

   // ****************************************
   // state
   // ****************************************
   logic [15:0] target_r [2];
   logic [15:0] target_nxt [2];
   logic [15:0] offset_r [2];
   logic [15:0] offset_nxt [2];
   logic [15:0] ceil_r [2];
   logic [15:0] ceil_nxt [2];
   logic [15:0] ceil_used_r [2];
   logic [15:0] ceil_used_nxt [2];
   logic [15:0] boot_r [2];
   logic [15:0] boot_nxt [2];
   logic [15:0] goal_r [2];
   logic [15:0] goal_nxt [2];
   logic [15:0] ref_r [2];
   logic [15:0] ref_nxt [2];
   logic [15:0] acc_r [2];
   logic [15:0] acc_nxt [2];
   logic [7:0] img_r [2];
   logic [7:0] img_nxt [2];
   logic [1:0] en_q_r;
   logic boot_pend_r;
   logic snap_r;
   logic snap_nxt;
   logic ack_r;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic inval_r;
   logic inval_nxt;

   // ****************************************
   // next values
   // ****************************************
   always_comb begin
      logic wr;
      logic bad;
      logic act;
      logic half;
      logic upd;
      logic [15:0] w;
      logic [7:0] ob;
      logic [1:0] e;
      logic [15:0] mant;
      wr = 1'b0;
      bad = 1'b0;
      act = 1'b0;
      half = 1'b0;
      upd = 1'b0;
      w = cmd_wdata_in;
      ob = 8'h00;
      e = offset_range_extend_in;
      mant = {2'h0, output_slew_setting_in[10:0], 3'h0}; // R5
      snap_nxt = boot_pend_r;
      rdata_nxt = rdata_r;
      for (int ch = 0; ch < 2; ch++) begin
         target_nxt[ch] = target_r[ch];
         offset_nxt[ch] = offset_r[ch];
         ceil_nxt[ch] = ceil_r[ch];
         ceil_used_nxt[ch] = ceil_used_r[ch];
         boot_nxt[ch] = boot_r[ch];
         goal_nxt[ch] = goal_r[ch];
         act = conversion_active_in[ch];
         half = feedback_loop_scale_in[ch];
         wr = cmd_valid_in && cmd_write_in && (cmd_page_in == ch[0]);
         upd = phase_event_in[ch] || !act; // R17
         if (boot_pend_r) begin
            ob = ch == 0 ? nvm_offset_a_in : nvm_offset_b_in;
            offset_nxt[ch] = 16'($signed({{8{ob[7]}}, ob}) <<< e);
            if (ch == 0 && boot_source_select_in) begin
               boot_nxt[ch] = channel_a_boot_strap_pin_in; // R11
               ceil_nxt[ch] = channel_a_boot_strap_pin_in <=
                  vtl_pkg::LIM_LOW ? vtl_pkg::LIM_LOW
                                   : vtl_pkg::LIM_MID; // R19
            end else begin
               boot_nxt[ch] = ch == 0 ? nvm_target_a_in
                                      : nvm_target_b_in; // R11 R12
               ceil_nxt[ch] = ch == 0 ? nvm_ceiling_a_in
                                      : nvm_ceiling_b_in; // R18
            end
            target_nxt[ch] = boot_nxt[ch];
            upd = 1'b1;
         end else if (channel_enable_in[ch] && !en_q_r[ch] &&
                      boot_restore_control_in) begin
            target_nxt[ch] = boot_r[ch]; // R13
            upd = 1'b1;
         end else if (wr) begin
            unique case (cmd_code_in)
               vtl_pkg::CMD_TARGET: begin
                  if (!avs_control_in) begin // R4
                     if (sum_ok(sum_of(w, offset_r[ch]),
                                ceil_r[ch], half)) begin // R8
                        target_nxt[ch] = w; // R3 R21
                        upd = 1'b1; // R17
                     end else begin
                        bad = 1'b1; // R9
                     end
                  end
               end
               vtl_pkg::CMD_OFFSET: begin
                  if (sum_ok(sum_of(target_r[ch], w),
                             ceil_r[ch], half)) begin
                     offset_nxt[ch] = w; // R14 R21
                     upd = 1'b1;
                  end else begin
                     bad = 1'b1; // R9
                  end
               end
               vtl_pkg::CMD_CEIL: begin
                  if (w > vtl_pkg::LIM_HIGH ||
                      (act && ((w > vtl_pkg::LIM_LOW) !=
                               (ceil_r[ch] > vtl_pkg::LIM_LOW))) ||
                      (act && !half && w > vtl_pkg::LIM_MID))
                     bad = 1'b1; // R9 R10
                  else
                     ceil_nxt[ch] = w; // R20
               end
               vtl_pkg::CMD_FORMAT: bad = 1'b1;
               default: ;
            endcase
         end
         if (upd) begin
            ceil_used_nxt[ch] = ceil_nxt[ch]; // R17
            goal_nxt[ch] = clamp(sum_of(target_nxt[ch], offset_nxt[ch]),
                                 ceil_nxt[ch],
                                 output_voltage_floor_in); // R6
         end
         // ramp by fractional accumulation of the slew mantissa
         ref_nxt[ch] = ref_r[ch];
         acc_nxt[ch] = vtl_pkg::ZERO16;
         if (snap_r) begin
            ref_nxt[ch] = goal_r[ch];
         end else if (ref_r[ch] != goal_r[ch]) begin
            acc_nxt[ch] = acc_r[ch] + mant; // R5
            if (acc_nxt[ch] >= vtl_pkg::STEP_COST) begin
               acc_nxt[ch] = acc_nxt[ch] - vtl_pkg::STEP_COST;
               ref_nxt[ch] = ref_r[ch] < goal_r[ch] ? ref_r[ch] + 16'h0001
                                                    : ref_r[ch] - 16'h0001;
            end
         end
         img_nxt[ch] = {offset_r[ch][15],
                        7'(offset_r[ch] >> e)}; // R15 R16
      end
      if (cmd_valid_in && !cmd_write_in) begin
         unique case (cmd_code_in)
            vtl_pkg::CMD_FORMAT: rdata_nxt = {8'h00, vtl_pkg::FMT_REL,
               vtl_pkg::FMT_MODE_LIN, vtl_pkg::FMT_FORMAT_PARAMETER}; // R1 R2
            vtl_pkg::CMD_TARGET:
               rdata_nxt = target_r[cmd_page_in]; // R3 R21
            vtl_pkg::CMD_OFFSET:
               rdata_nxt = offset_r[cmd_page_in]; // R21
            vtl_pkg::CMD_CEIL: rdata_nxt = ceil_r[cmd_page_in];
            default: rdata_nxt = vtl_pkg::ZERO16;
         endcase
      end
      // new invalid data wins over a clear in the same cycle
      inval_nxt = bad || (inval_r && !status_clear_in); // R9 R7
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         for (int ch = 0; ch < 2; ch++) begin
            target_r[ch] <= vtl_pkg::ZERO16;
            offset_r[ch] <= vtl_pkg::ZERO16;
            ceil_r[ch] <= vtl_pkg::ZERO16;
            ceil_used_r[ch] <= vtl_pkg::ZERO16;
            boot_r[ch] <= vtl_pkg::ZERO16;
            goal_r[ch] <= vtl_pkg::ZERO16;
            ref_r[ch] <= vtl_pkg::ZERO16;
            acc_r[ch] <= vtl_pkg::ZERO16;
            img_r[ch] <= 8'h00;
         end
         en_q_r <= 2'h0;
         boot_pend_r <= 1'b1;
         snap_r <= 1'b0;
         ack_r <= 1'b0;
         rdata_r <= vtl_pkg::ZERO16;
         inval_r <= 1'b0;
      end else begin
         target_r <= target_nxt;
         offset_r <= offset_nxt;
         ceil_r <= ceil_nxt;
         ceil_used_r <= ceil_used_nxt;
         boot_r <= boot_nxt;
         goal_r <= goal_nxt;
         ref_r <= ref_nxt;
         acc_r <= acc_nxt;
         img_r <= img_nxt;
         en_q_r <= channel_enable_in;
         boot_pend_r <= 1'b0;
         snap_r <= snap_nxt;
         ack_r <= cmd_valid_in;
         rdata_r <= rdata_nxt;
         inval_r <= inval_nxt;
      end
   end

   assign cmd_ack_out = ack_r;
   assign cmd_rdata_out = rdata_r;
   assign invalid_data_out = inval_r;
   assign dac_ref_a_out = ref_r[0];
   assign dac_ref_b_out = ref_r[1];
   assign nvm_offset_image_a_out = img_r[0];
   assign nvm_offset_image_b_out = img_r[1];

   // ****************************************
   // checks
   // ****************************************
   logic bad_seen;
   assign bad_seen = cmd_valid_in && cmd_write_in && !boot_pend_r &&
      channel_enable_in == en_q_r && cmd_code_in == vtl_pkg::CMD_FORMAT;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_fmt_rd;
      cmd_valid_in && !cmd_write_in && cmd_code_in == vtl_pkg::CMD_FORMAT;
   endsequence
   chk_format_read: assert property (s_fmt_rd |=> // R1
      cmd_rdata_out[7:0] == 8'h16) else $error("format byte wrong");
   chk_format_format_parameter: assert property (s_fmt_rd |=> // R2
      cmd_rdata_out[4:0] == 5'h16) else $error("format_parameter wrong");
   chk_avs_block: assert property ( // R4
      cmd_valid_in && cmd_write_in && cmd_code_in == vtl_pkg::CMD_TARGET &&
      avs_control_in && !boot_pend_r && channel_enable_in == en_q_r
      |=> $stable(target_r[0]) && $stable(target_r[1]))
      else $error("target taken under avs");
   chk_ramp_step: assert property (!snap_r |=> // R5
      16'(ref_r[0] - $past(ref_r[0])) inside {16'h0000, 16'h0001, 16'hffff})
      else $error("reference stepped");
   chk_clamp_ceil: assert property (goal_r[0] <= ceil_used_r[0] || // R6
      goal_r[0] == output_voltage_floor_in ||
      $changed(output_voltage_floor_in)) else $error("goal above ceiling");
   chk_bad_flag: assert property (bad_seen |=> invalid_data_out) // R9
      else $error("invalid data not flagged");
   chk_ceil_cross: assert property (conversion_active_in[0] && // R10
      !$past(boot_pend_r) && $past(conversion_active_in[0]) |->
      ((ceil_r[0] > vtl_pkg::LIM_LOW) == ($past(ceil_r[0]) >
      vtl_pkg::LIM_LOW))) else $error("ceiling crossed band");
   chk_boot_b: assert property (boot_pend_r |=> // R12
      target_r[1] == $past(nvm_target_b_in)) else $error("channel b boot");
   chk_img_sign: assert property (##1 // R15
      nvm_offset_image_a_out[7] == $past(offset_r[0][15]))
      else $error("image sign");
endmodule : vtl_core
`default_nettype wire

//--- vtl_pkg.sv
`default_nettype none
package vtl_pkg;
   // ****************************************
   // command codes
   // ****************************************
   localparam logic [7:0] CMD_FORMAT = 8'h20;
   localparam logic [7:0] CMD_TARGET = 8'h21;
   localparam logic [7:0] CMD_OFFSET = 8'h22;
   localparam logic [7:0] CMD_CEIL = 8'h24;
   // ****************************************
   // format descriptor fields
   // ****************************************
   localparam int FMT_REL_POS = 7;
   localparam int FMT_MODE_MSB = 6;
   localparam int FMT_MODE_LSB = 5;
   localparam logic FMT_REL = 1'h0;
   localparam logic [1:0] FMT_MODE_LIN = 2'h0;
   localparam logic [4:0] FMT_FORMAT_PARAMETER = 5'h16;
   // ****************************************
   // voltage limits, 0.9765625 mV per lsb
   // ****************************************
   localparam logic [15:0] LIM_LOW = 16'h077a;
   localparam logic [15:0] LIM_MID = 16'h0ef5;
   localparam logic [15:0] LIM_HIGH = 16'h1600;
   // ****************************************
   // slew timing
   // ****************************************
   localparam int CLK_MHZ = 50;
   // one lsb is 125/8 slew units of 0.0625 mV
   localparam int LSB_EIGHTHS = 125;
   localparam logic [15:0] STEP_COST = 16'(LSB_EIGHTHS * CLK_MHZ);
   localparam logic [15:0] ZERO16 = 16'h0000;
endpackage : vtl_pkg
`default_nettype wire

//--- vtl_host.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// word command host
// ****************************************
module vtl_host (
   input wire logic clock_in,
   input wire logic cmd_ack_in,
   output logic cmd_valid_out,
   output logic cmd_write_out,
   output logic cmd_page_out,
   output logic [7:0] cmd_code_out,
   output logic [15:0] cmd_wdata_out
);
   initial begin
      cmd_valid_out = 1'b0;
      cmd_write_out = 1'b0;
      cmd_page_out = 1'b0;
      cmd_code_out = 8'hff;
      cmd_wdata_out = 16'h0000;
   end
   // one word per request, valid for a single edge, then await the ack
   task automatic word_cmd(input logic wr, input logic pg,
         input logic [7:0] code, input logic [15:0] data,
         output bit ok);
      int n;
      ok = 1'b0;
      @(negedge clock_in);
      cmd_valid_out = 1'b1;
      cmd_write_out = wr;
      cmd_page_out = pg;
      cmd_code_out = code;
      cmd_wdata_out = data;
      @(negedge clock_in);
      cmd_valid_out = 1'b0;
      // released code, data and write lines carry junk rather than the last word
      cmd_code_out = ~code;
      cmd_wdata_out = ~data;
      cmd_write_out = ~wr;
      for (n = 0; n < 4 && !ok; n++) begin
         if (cmd_ack_in === 1'b1) ok = 1'b1;
         else @(negedge clock_in);
      end
   endtask : word_cmd
endmodule : vtl_host
`default_nettype wire

//--- vout_target_limit_logic_tb.sv
`timescale 1ns/100ps
`default_nettype none
module vout_target_limit_logic_tb;
   logic clk = 1'b0, rst_n = 1'b0, avs = 1'b0, boot_sel = 1'b0;
   logic restore = 1'b0, clr = 1'b0;
   logic [1:0] conv = 2'h0, en = 2'h0, phase = 2'h0, scale = 2'h0;
   logic [1:0] rext = 2'h1;
   logic [15:0] floor_v = 16'h0100, slew = 16'he280, strap = 16'h0500;
   logic [15:0] nt_a = 16'h0400, nt_b = 16'h0300;
   logic [15:0] nc_a = 16'h0700, nc_b = 16'h077a;
   logic [7:0] no_a = 8'h00, no_b = 8'h85;
   logic cmd_valid, cmd_write, cmd_page, ack, inval;
   logic [7:0] cmd_code, img_a, img_b;
   logic [15:0] cmd_wdata, rdata, dac_a, dac_b, v, e;
   int fail_count = 0, checked = 0, i;
   bit c;
   bit cq[$];
   logic [15:0] eq[$];
   // ****************************************
   // design and host
   // ****************************************
   vtl_core vtl_core_i (.clock_in(clk), .rst_n_in(rst_n),
      .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
      .cmd_page_in(cmd_page), .cmd_code_in(cmd_code),
      .cmd_wdata_in(cmd_wdata), .avs_control_in(avs),
      .conversion_active_in(conv), .channel_enable_in(en),
      .phase_event_in(phase), .feedback_loop_scale_in(scale),
      .output_voltage_floor_in(floor_v), .output_slew_setting_in(slew),
      .boot_source_select_in(boot_sel), .boot_restore_control_in(restore),
      .offset_range_extend_in(rext), .channel_a_boot_strap_pin_in(strap),
      .nvm_target_a_in(nt_a), .nvm_target_b_in(nt_b),
      .nvm_ceiling_a_in(nc_a), .nvm_ceiling_b_in(nc_b),
      .nvm_offset_a_in(no_a), .nvm_offset_b_in(no_b),
      .status_clear_in(clr), .cmd_ack_out(ack), .cmd_rdata_out(rdata),
      .invalid_data_out(inval), .dac_ref_a_out(dac_a),
      .dac_ref_b_out(dac_b), .nvm_offset_image_a_out(img_a),
      .nvm_offset_image_b_out(img_b));
   vtl_host vtl_host_i (.clock_in(clk), .cmd_ack_in(ack),
      .cmd_valid_out(cmd_valid), .cmd_write_out(cmd_write),
      .cmd_page_out(cmd_page), .cmd_code_out(cmd_code),
      .cmd_wdata_out(cmd_wdata));
   always #10 clk = ~clk;
   // ****************************************
   // checking helpers
   // ****************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic stop_test();
      if (fail_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test
   task automatic cmd(input logic wr, input logic pg, input logic [7:0] cd,
         input logic [15:0] d, input bit rd_chk, input logic [15:0] x);
      bit ok;
      cq.push_back(rd_chk);
      eq.push_back(x);
      vtl_host_i.word_cmd(wr, pg, cd, d, ok);
      chk({15'h0000, ok}, 16'h0001);
   endtask : cmd
   task automatic wr(input logic pg, input logic [7:0] cd,
         input logic [15:0] d);
      cmd(1'b1, pg, cd, d, 1'b0, 16'h0000);
   endtask : wr
   task automatic rd(input logic pg, input logic [7:0] cd,
         input logic [15:0] x);
      cmd(1'b0, pg, cd, 16'h0000, 1'b1, x);
   endtask : rd
   task automatic flag(input logic x);
      repeat (2) @(negedge clk);
      chk({15'h0000, inval}, {15'h0000, x});
   endtask : flag
   task automatic clear_flag();
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      flag(1'b0);
   endtask : clear_flag
   task automatic settle(input logic [15:0] x);
      int n;
      n = 0;
      while (dac_a !== x && n < 3000) begin
         @(negedge clk);
         n++;
      end
      chk(dac_a, x);
   endtask : settle
   task automatic do_reset(input logic sel, input logic [15:0] pin);
      @(negedge clk);
      rst_n = 1'b0;
      boot_sel = sel;
      strap = pin;
      restore = 1'b0;
      en = 2'h0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
   endtask : do_reset
   // ****************************************
   // read monitor
   // ****************************************
   always @(negedge clk) begin
      if (ack === 1'b1) begin
         if (cq.size() == 0) begin
            chk({15'h0000, ack}, 16'h0000);
         end else begin
            c = cq.pop_front();
            e = eq.pop_front();
            if (c) chk(rdata, e);
         end
      end
   end
   initial begin
      #400000;
      fail_count++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      stop_test();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      v = 16'($urandom(32'h5202d1b2));
      do_reset(1'b0, 16'h0500);
      rd(1'b0, vtl_pkg::CMD_FORMAT, 16'h0016);
      rd(1'b1, vtl_pkg::CMD_FORMAT, 16'h0016);
      rd(1'b0, vtl_pkg::CMD_TARGET, 16'h0400);
      rd(1'b1, vtl_pkg::CMD_TARGET, 16'h0300);
      rd(1'b0, vtl_pkg::CMD_CEIL, 16'h0700);
      rd(1'b1, vtl_pkg::CMD_OFFSET, 16'hff0a);
      chk({8'h00, img_b}, 16'h0085);
      chk(dac_b, 16'h020a);
      wr(1'b0, vtl_pkg::CMD_TARGET, 16'h0600);
      @(negedge clk);
      chk({15'h0000, dac_a < 16'h0420}, 16'h0001);
      repeat (100) @(negedge clk);
      chk({15'h0000, dac_a > 16'h0440 && dac_a < 16'h0460}, 16'h0001);
      settle(16'h0600);
      for (i = 0; i < 4; i++) begin
         v = 16'h0100 + 16'($urandom_range(1536));
         wr(1'b0, vtl_pkg::CMD_TARGET, v);
         rd(1'b0, vtl_pkg::CMD_TARGET, v);
      end
      wr(1'b0, vtl_pkg::CMD_TARGET, 16'h0750);
      settle(16'h0700);
      flag(1'b0);
      rd(1'b0, vtl_pkg::CMD_TARGET, 16'h0750);
      wr(1'b0, vtl_pkg::CMD_TARGET, 16'h0080);
      settle(16'h0100);
      rd(1'b0, vtl_pkg::CMD_TARGET, 16'h0080);
      wr(1'b0, vtl_pkg::CMD_OFFSET, 16'h0014);
      repeat (2) @(negedge clk);
      chk({8'h00, img_a}, 16'h000a);
      rd(1'b0, vtl_pkg::CMD_OFFSET, 16'h0014);
      wr(1'b0, vtl_pkg::CMD_OFFSET, 16'h0000);
      wr(1'b0, vtl_pkg::CMD_TARGET, 16'h077b);
      flag(1'b1);
      rd(1'b0, vtl_pkg::CMD_TARGET, 16'h0080);
      clear_flag();
      wr(1'b0, vtl_pkg::CMD_FORMAT, 16'h00ff);
      flag(1'b1);
      clear_flag();
      wr(1'b0, vtl_pkg::CMD_OFFSET, 16'h7000);
      flag(1'b1);
      rd(1'b0, vtl_pkg::CMD_OFFSET, 16'h0000);
      clear_flag();
      avs = 1'b1;
      wr(1'b0, vtl_pkg::CMD_TARGET, 16'h0123);
      flag(1'b0);
      rd(1'b0, vtl_pkg::CMD_TARGET, 16'h0080);
      avs = 1'b0;
      rd(1'b0, 8'h23, 16'h0000);
      wr(1'b0, vtl_pkg::CMD_CEIL, 16'h1600);
      flag(1'b0);
      rd(1'b0, vtl_pkg::CMD_CEIL, 16'h1600);
      wr(1'b0, vtl_pkg::CMD_CEIL, 16'h1601);
      flag(1'b1);
      clear_flag();
      wr(1'b0, vtl_pkg::CMD_CEIL, 16'h0700);
      conv = 2'h1;
      wr(1'b0, vtl_pkg::CMD_CEIL, 16'h0800);
      flag(1'b1);
      rd(1'b0, vtl_pkg::CMD_CEIL, 16'h0700);
      clear_flag();
      wr(1'b0, vtl_pkg::CMD_TARGET, 16'h0600);
      settle(16'h0600);
      wr(1'b0, vtl_pkg::CMD_CEIL, 16'h0500);
      repeat (20) @(negedge clk);
      chk(dac_a, 16'h0600);
      phase = 2'h1;
      @(negedge clk);
      phase = 2'h0;
      settle(16'h0500);
      conv = 2'h0;
      do_reset(1'b1, 16'h0500);
      rd(1'b0, vtl_pkg::CMD_TARGET, 16'h0500);
      rd(1'b0, vtl_pkg::CMD_CEIL, 16'h077a);
      rd(1'b1, vtl_pkg::CMD_TARGET, 16'h0300);
      wr(1'b0, vtl_pkg::CMD_TARGET, 16'h0200);
      restore = 1'b1;
      en = 2'h1;
      repeat (3) @(negedge clk);
      rd(1'b0, vtl_pkg::CMD_TARGET, 16'h0500);
      do_reset(1'b1, 16'h0800);
      rd(1'b0, vtl_pkg::CMD_CEIL, 16'h0ef5);
      wr(1'b0, vtl_pkg::CMD_TARGET, 16'h1000);
      flag(1'b1);
      clear_flag();
      scale = 2'h1;
      wr(1'b0, vtl_pkg::CMD_TARGET, 16'h1000);
      flag(1'b0);
      rd(1'b0, vtl_pkg::CMD_TARGET, 16'h1000);
      repeat (2) @(negedge clk);
      stop_test();
   end
endmodule : vout_target_limit_logic_tb
`default_nettype wire
